/* rtl/pwr_regs_pkg.sv */
// package: register map, field positions and level limits of the
// supply status and level register bank
// assumes: a 32-bit AHB-Lite bus with byte addressing
package pwr_regs_pkg;

  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_SUPPLY_STATUS = 8'h30;
  localparam logic [7:0] OFS_CORE_LEVEL = 8'h34;
  localparam logic [7:0] OFS_PLL_LEVEL = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h50;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h54;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h58;

  // status bit positions
  localparam int BIT_CORE_SOFT_START = 0;
  localparam int BIT_ANA_SOFT_START = 1;
  localparam int BIT_CORE_CUR_LIMIT = 8;
  localparam int BIT_ANA_CUR_LIMIT = 9;
  localparam int BIT_CORE_RAIL_GOOD = 16;
  localparam int BIT_PLL_RAIL_GOOD = 19;
  localparam int BIT_OSC_STABLE = 24;

  // live status bits as a mask
  localparam logic [31:0] STATUS_MASK = 32'h0109_0303;

  // level field widths and limits
  localparam int CORE_LEVEL_W = 7;
  localparam int PLL_LEVEL_W = 3;
  localparam logic [6:0] CORE_LEVEL_MAX = 7'h46;
  localparam logic [2:0] PLL_LEVEL_MAX = 3'h6;

  // interrupt event count: one per live status bit
  localparam int NUM_EVENTS = 7;

  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

/* rtl/pwr_edge_events.sv */
// edge detector: turns changes of live status bits into one-cycle events
// assumes: status inputs already synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module pwr_edge_events #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // live bits and their change pulses
  input wire logic [WIDTH-1:0] live,
  output logic [WIDTH-1:0] changed
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic armed;
  } edge_s;

  edge_s st;
  edge_s next_st;

  // remember last value; first cycle after reset reports nothing
  always_comb begin
    next_st = st;
    next_st.prev = live;
    next_st.armed = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign changed = st.armed ? (live ^ st.prev) : '0;

endmodule
`default_nettype wire

/* rtl/pwr_supply_regs.sv */
// What this block does
// - status bit 24 reads one while on-chip oscillator is stable.
// - status bit 16 reads one while core supply rail is good.
// - status bit 19 reads one while pll supply rail is good.
// - bits 9 and 8 show analogue and core buck current limiting.
// - bits 1 and 0 show analogue and core buck soft-start.
// - status register at 0x30 is read-only and shows live state.
// - core level at 0x34, bits 6:0, 0.60V plus 10 mV per code.
// - reset values of both level fields come from strap pins.
// - pll regulator level at 0x40, 0.6V plus 100 mV per code.
//
// file: supply status and level register bank behind an AHB-Lite slave
// assumes: status and strap inputs synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module pwr_supply_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [pwr_regs_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // live supply state
  input wire logic osc_stable,
  input wire logic core_supply_rail_good,
  input wire logic pll_supply_rail_good,
  input wire logic analogue_buck_converter_cur_limit,
  input wire logic core_buck_converter_cur_limit,
  input wire logic analogue_buck_converter_soft_start,
  input wire logic core_buck_converter_soft_start,
  // strap-derived reset levels
  input wire logic [pwr_regs_pkg::CORE_LEVEL_W-1:0] strap_core_level,
  input wire logic [pwr_regs_pkg::PLL_LEVEL_W-1:0] strap_pll_level,
  // level requests to the converters
  output logic [pwr_regs_pkg::CORE_LEVEL_W-1:0] core_supply_rail_level,
  output logic [pwr_regs_pkg::PLL_LEVEL_W-1:0] pll_linear_regulator_level,
  // interrupt
  output logic irq
);
  import pwr_regs_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic strap_loaded;
    logic [CORE_LEVEL_W-1:0] core_level;
    logic [PLL_LEVEL_W-1:0] pll_level;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_enable;
  } regs_s;

  regs_s st;
  regs_s next_st;
  logic [31:0] status_word;
  logic [NUM_EVENTS-1:0] live_bits;
  logic [NUM_EVENTS-1:0] events;
  logic addr_phase;

  // live status word, every other bit zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[BIT_OSC_STABLE] = osc_stable;
    status_word[BIT_CORE_RAIL_GOOD] = core_supply_rail_good;
    status_word[BIT_PLL_RAIL_GOOD] = pll_supply_rail_good;
    status_word[BIT_ANA_CUR_LIMIT] =
      analogue_buck_converter_cur_limit;
    status_word[BIT_CORE_CUR_LIMIT] =
      core_buck_converter_cur_limit;
    status_word[BIT_ANA_SOFT_START] =
      analogue_buck_converter_soft_start;
    status_word[BIT_CORE_SOFT_START] =
      core_buck_converter_soft_start;
  end

  // compact event vector in status bit order, low to high
  assign live_bits = {status_word[BIT_OSC_STABLE],
                      status_word[BIT_PLL_RAIL_GOOD],
                      status_word[BIT_CORE_RAIL_GOOD],
                      status_word[BIT_ANA_CUR_LIMIT],
                      status_word[BIT_CORE_CUR_LIMIT],
                      status_word[BIT_ANA_SOFT_START],
                      status_word[BIT_CORE_SOFT_START]};

  // any change of a live status bit is an event
  pwr_edge_events #(
    .WIDTH(NUM_EVENTS)
  ) u_events (
    .core_clk(core_clk),
    .rst(rst),
    .live(live_bits),
    .changed(events)
  );

  // valid address phase of a transfer to this slave
  assign addr_phase = hsel && hready && htrans[1];

  // read decode; unmapped reads give zero
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] a,
    input regs_s s,
    input logic [31:0] stat
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_SUPPLY_STATUS: w = stat & STATUS_MASK;
      OFS_CORE_LEVEL: w[CORE_LEVEL_W-1:0] = s.core_level;
      OFS_PLL_LEVEL: w[PLL_LEVEL_W-1:0] = s.pll_level;
      OFS_IRQ_STATUS: w[NUM_EVENTS-1:0] = s.irq_status;
      OFS_IRQ_ENABLE: w[NUM_EVENTS-1:0] = s.irq_enable;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // next state: bus writes, reads, straps, sticky events
  always_comb begin
    next_st = st;
    // strap values taken on the first clock after reset release
    next_st.strap_loaded = 1'b1;
    if (!st.strap_loaded) begin
      next_st.core_level = strap_core_level;
      next_st.pll_level = strap_pll_level;
    end
    // data phase of a pending write
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        OFS_CORE_LEVEL: begin
          // only bits 6:0 stored, upper bits dropped
          next_st.core_level = hwdata[CORE_LEVEL_W-1:0];
        end
        OFS_PLL_LEVEL: begin
          next_st.pll_level = hwdata[PLL_LEVEL_W-1:0];
        end
        OFS_IRQ_ENABLE: begin
          next_st.irq_enable = hwdata[NUM_EVENTS-1:0];
        end
        OFS_IRQ_CLEAR: begin
          next_st.irq_status = st.irq_status & ~hwdata[NUM_EVENTS-1:0];
        end
        default: begin
          // status and unmapped writes are ignored
          next_st.wr_pend = 1'b0;
        end
      endcase
    end
    // new events win over a clear in the same cycle
    next_st.irq_status = next_st.irq_status | events;
    // address phase: capture writes, prepare read data
    if (addr_phase && hwrite) begin
      next_st.wr_pend = 1'b1;
      next_st.wr_addr = haddr;
    end
    if (addr_phase && !hwrite) begin
      next_st.rdata = read_word(haddr, st, status_word);
    end else begin
      next_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign core_supply_rail_level = st.core_level;
  assign pll_linear_regulator_level = st.pll_level;
  assign irq = |(st.irq_status & st.irq_enable);

endmodule
`default_nettype wire

/* testbench/pwr_supply_regs_props.sv */
// checker: bus-visible relations of the supply register bank
// assumes: bound into pwr_supply_regs, hready fed from hreadyout
`timescale 1ns/100ps
`default_nettype none
module pwr_supply_regs_props (
  // clock, reset and bus
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [pwr_regs_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // live state, straps and levels
  input wire logic osc_stable,
  input wire logic core_supply_rail_good,
  input wire logic pll_supply_rail_good,
  input wire logic analogue_buck_converter_cur_limit,
  input wire logic core_buck_converter_cur_limit,
  input wire logic analogue_buck_converter_soft_start,
  input wire logic core_buck_converter_soft_start,
  input wire logic [pwr_regs_pkg::CORE_LEVEL_W-1:0] strap_core_level,
  input wire logic [pwr_regs_pkg::PLL_LEVEL_W-1:0] strap_pll_level,
  input wire logic [pwr_regs_pkg::CORE_LEVEL_W-1:0] core_supply_rail_level,
  input wire logic [pwr_regs_pkg::PLL_LEVEL_W-1:0] pll_linear_regulator_level
);
  import pwr_regs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // address-phase decode
  logic rd_st, rd_core, wr_core, wr_pll;
  assign rd_st = hsel && hready && htrans[1] && !hwrite
    && haddr == OFS_SUPPLY_STATUS;
  assign rd_core = hsel && hready && htrans[1] && !hwrite
    && haddr == OFS_CORE_LEVEL;
  assign wr_core = hsel && hready && htrans[1] && hwrite
    && haddr == OFS_CORE_LEVEL;
  assign wr_pll = hsel && hready && htrans[1] && hwrite
    && haddr == OFS_PLL_LEVEL;
  a_osc_bit: assert property (rd_st |=>
    hrdata[24] == $past(osc_stable))
    else $error("status bit 24 wrong");
  a_core_good: assert property (rd_st |=>
    hrdata[16] == $past(core_supply_rail_good))
    else $error("status bit 16 wrong");
  a_pll_good: assert property (rd_st |=>
    hrdata[19] == $past(pll_supply_rail_good))
    else $error("status bit 19 wrong");
  a_cur_limit: assert property (rd_st |=> hrdata[9:8] ==
    {$past(analogue_buck_converter_cur_limit),
     $past(core_buck_converter_cur_limit)})
    else $error("current limit bits wrong");
  a_soft_start: assert property (rd_st |=> hrdata[1:0] ==
    {$past(analogue_buck_converter_soft_start),
     $past(core_buck_converter_soft_start)})
    else $error("soft-start bits wrong");
  a_status_rsvd: assert property (rd_st |=> (hrdata & ~STATUS_MASK) == 0)
    else $error("status reserved bits set");
  a_core_rd: assert property (rd_core |=> hrdata ==
    {25'h0, $past(core_supply_rail_level)})
    else $error("core level read wrong");
  a_core_wr: assert property (wr_core |=> ##1
    core_supply_rail_level == $past(hwdata[6:0]))
    else $error("core level not stored");
  a_pll_wr: assert property (wr_pll |=> ##1
    pll_linear_regulator_level == $past(hwdata[2:0]))
    else $error("pll level not stored");
  a_strap_load: assert property ($fell(rst) |=>
    core_supply_rail_level == $past(strap_core_level)
    && pll_linear_regulator_level == $past(strap_pll_level))
    else $error("strap levels not loaded");
endmodule
bind pwr_supply_regs pwr_supply_regs_props u_props (.*);
`default_nettype wire

/* testbench/pwr_supply_regs_tb_top.sv */
// testbench: register sequences over AHB-Lite with expected values
// assumes: one slave, hready fed back from hreadyout
`timescale 1ns/100ps
`default_nettype none
module pwr_supply_regs_tb_top;
  import pwr_regs_pkg::*;
  localparam logic [7:0] ST = OFS_SUPPLY_STATUS;
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic [6:0] live = 7'h00, core_lvl;
  logic [2:0] pll_lvl;
  logic [6:0] strap_core = 7'h2A;
  logic [2:0] strap_pll = 3'h5;
  logic [31:0] m [7] = '{32'h1, 32'h2, 32'h100, 32'h200, 32'h1_0000,
    32'h8_0000, 32'h100_0000};
  int fail_count = 0, n_checks = 0;
  // device under test, live bits in event order
  pwr_supply_regs DUT (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(HSIZE_WORD), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .osc_stable(live[6]), .pll_supply_rail_good(live[5]),
    .core_supply_rail_good(live[4]),
    .analogue_buck_converter_cur_limit(live[3]),
    .core_buck_converter_cur_limit(live[2]),
    .analogue_buck_converter_soft_start(live[1]),
    .core_buck_converter_soft_start(live[0]),
    .strap_core_level(strap_core), .strap_pll_level(strap_pll),
    .core_supply_rail_level(core_lvl), .pll_linear_regulator_level(pll_lvl),
    .irq);
  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait for hready, data taken at the sampling edge
  task automatic rdy(output logic [31:0] d);
    int i;
    i = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        fail_count++;
        report_and_stop;
      end
      @(posedge core_clk);
    end
    d = hrdata;
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    rdy(q);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // core level moved one code per microsecond (200 cycles)
  task automatic ramp_core(input logic [6:0] from, input logic [6:0] to);
    logic [6:0] c;
    c = from;
    while (c != to) begin
      c = (c < to) ? c + 7'h01 : c - 7'h01;
      wr(OFS_CORE_LEVEL, {25'h0, c});
      repeat (200) @(posedge core_clk);
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd_chk(OFS_CORE_LEVEL, 32'h2A);
    rd_chk(OFS_PLL_LEVEL, 32'h5);
    $display("test straps done");
    for (int k = 0; k < 7; k++) begin
      live <= 7'h01 << k;
      rd_chk(ST, m[k]);
    end
    wr(ST, 32'hFFFF_FFFF);
    live <= 7'h00;
    rd_chk(ST, 32'h0);
    live <= 7'h7F;
    rd_chk(ST, STATUS_MASK);
    $display("test status done");
    ramp_core(7'h2A, 7'h45);
    wr(OFS_CORE_LEVEL, 32'hFFFF_FF46);
    rd_chk(OFS_CORE_LEVEL, 32'h46);
    chk({25'h0, core_lvl}, 32'h46);
    repeat (200) @(posedge core_clk);
    ramp_core(7'h46, 7'h00);
    rd_chk(OFS_CORE_LEVEL, 32'h0);
    wr(OFS_PLL_LEVEL, 32'hFFFF_FFF6);
    rd_chk(OFS_PLL_LEVEL, 32'h6);
    chk({29'h0, pll_lvl}, 32'h6);
    $display("test levels done");
    rd_chk(OFS_IRQ_STATUS, 32'h7F);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h40);
    rd_chk(OFS_IRQ_ENABLE, 32'h40);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_CLEAR, 32'h7F);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    live <= 7'h3F;
    rd_chk(8'h10, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h40);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    rd_chk(OFS_IRQ_ENABLE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    strap_core <= 7'h10;
    strap_pll <= 3'h2;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd_chk(OFS_CORE_LEVEL, 32'h10);
    rd_chk(OFS_PLL_LEVEL, 32'h2);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    rd_chk(OFS_IRQ_ENABLE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test second reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
